//--- rtl/async_serial_channel_regs.vh
// Register offsets, field positions, reset values and timing counts of the serial channel.
`ifndef ASYNC_SERIAL_CHANNEL_REGS_VH
`define ASYNC_SERIAL_CHANNEL_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_MODE_ZERO  4'h0
`define OFS_MODE_ONE   4'h1
`define OFS_MODE_TWO   4'h2
`define OFS_CLK_SEL    4'h3
`define OFS_CMD_STAT   4'h4
`define OFS_QUEUE      4'h5
`define OFS_INT_STAT   4'h6
`define OFS_LEVELS     4'h7
// ****************************************
// Field positions
// ****************************************
`define MR0_WDOG_EN    7
`define MR1_ERR_BLOCK  5
`define MR1_PMODE_HI   4
`define MR1_PMODE_LO   3
`define MR1_PTYPE      2
`define MR2_TWO_STOP   0
`define CSEL_RX_16X    0
`define CSEL_TX_16X    1
`define ISR_BRK_CHG    2
`define ISR_WDOG       3
// ****************************************
// Parity modes and commands
// ****************************************
`define PM_WITH        2'h0
`define PM_FORCE       2'h1
`define PM_NONE        2'h2
`define PM_WAKEUP      2'h3
`define CMD_RX_EN      4'h1
`define CMD_RX_DIS     4'h2
`define CMD_TX_EN      4'h3
`define CMD_TX_DIS     4'h4
`define CMD_RX_RST     4'h5
`define CMD_TX_RST     4'h6
`define CMD_ERR_RST    4'h7
`define CMD_BRK_CLR    4'h8
`define CMD_BRK_START  4'h9
`define CMD_BRK_STOP   4'hA
`define CMD_WDOG_CLR   4'hB
// ****************************************
// Reset values and timing counts
// ****************************************
`define RST_MODE       8'h00
`define RST_CLK_SEL    8'h03
`define DIV_MID        4'h7
`define DIV_LAST       4'hF
`define WDOG_BIT_TIMES 7'h40
`define BRK_END_EDGES  2'h2
`endif

//--- rtl/async_serial_channel.v
// One full-duplex asynchronous serial channel with eight-deep queues.
//
// Added by the designer: the plain strobed port and the register offsets.
`include "async_serial_channel_regs.vh"
module async_serial_channel #(
  parameter QUEUE_AW = 3
) (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wr_data,
  input  wire       reg_wr_stb,
  input  wire       reg_rd_stb,
  output reg  [7:0] reg_rd_data,
  input  wire       tx_bit_clock,
  input  wire       rx_bit_clock,
  input  wire       rx_serial_in,
  output reg        tx_serial_out,
  output reg  [2:0] tx_free_level,
  output reg  [2:0] rx_fill_level
);
  localparam DEPTH = 1 << QUEUE_AW;
  localparam [QUEUE_AW:0] FULL_CNT = DEPTH;
  localparam [2:0] T_IDLE = 3'h0, T_DATA = 3'h1, T_STOP = 3'h2;
  localparam [2:0] R_HUNT = 3'h0, R_VALID = 3'h1, R_BITS = 3'h2, R_LOADW = 3'h3;
  localparam [2:0] R_BRK = 3'h4;
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  reg rst_a_r, rst_b_r;
  wire rst_n = rst_b_r;
  // Reset is applied at once and released through two flip-flops.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end
  // Bits: 0 transmit clock, 1 receive clock, 2 receive data.
  reg [2:0] s1_r, s2_r, s3_r, pin_r, pin_q_r;
  wire [2:0] agree = ~(s2_r ^ s3_r);
  wire [2:0] rise = pin_r & ~pin_q_r;
  wire [2:0] fall = ~pin_r & pin_q_r;
  // A pin level is taken once the second and third stages agree.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      s3_r <= 3'h7;
      pin_r <= 3'h7;
      pin_q_r <= 3'h7;
    end else if (clk_en) begin
      s1_r <= {rx_serial_in, rx_bit_clock, tx_bit_clock};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (pin_r & ~agree) | (s3_r & agree);
      pin_q_r <= pin_r;
    end
  end
  wire rxd = pin_r[2];
  // ****************************************
  // Registers and commands
  // ****************************************
  reg [7:0] mr0_r, mr1_r, mr2_r, csel_r;
  reg tx_en_r, rx_en_r, brk_r;
  wire cmd_wr = reg_wr_stb & (reg_addr == `OFS_CMD_STAT);
  wire [3:0] cmd = reg_wr_data[3:0];
  wire cmd_rx_rst = cmd_wr & (cmd == `CMD_RX_RST);
  wire cmd_tx_rst = cmd_wr & (cmd == `CMD_TX_RST);
  wire cmd_err_rst = cmd_wr & (cmd == `CMD_ERR_RST);
  wire [1:0] pmode = mr1_r[`MR1_PMODE_HI:`MR1_PMODE_LO];
  wire wakeup = (pmode == `PM_WAKEUP);
  wire [3:0] clen = 4'h5 + {2'h0, mr1_r[1:0]};
  wire rx16 = csel_r[`CSEL_RX_16X];
  wire tx16 = csel_r[`CSEL_TX_16X];
  // Mode, clock select, enables and the break request.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mr0_r <= `RST_MODE;
      mr1_r <= `RST_MODE;
      mr2_r <= `RST_MODE;
      csel_r <= `RST_CLK_SEL;
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      brk_r <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr_stb & (reg_addr == `OFS_MODE_ZERO)) mr0_r <= reg_wr_data;
      if (reg_wr_stb & (reg_addr == `OFS_MODE_ONE)) mr1_r <= reg_wr_data;
      if (reg_wr_stb & (reg_addr == `OFS_MODE_TWO)) mr2_r <= reg_wr_data;
      if (reg_wr_stb & (reg_addr == `OFS_CLK_SEL)) csel_r <= reg_wr_data;
      if (cmd_wr) begin
        case (cmd)
          `CMD_RX_EN: rx_en_r <= 1'b1;
          `CMD_RX_DIS, `CMD_RX_RST: rx_en_r <= 1'b0;
          `CMD_TX_EN: tx_en_r <= 1'b1;
          `CMD_TX_DIS: tx_en_r <= 1'b0;
          `CMD_TX_RST: begin
            tx_en_r <= 1'b0;
            brk_r <= 1'b0;
          end
          `CMD_BRK_START: brk_r <= 1'b1;
          `CMD_BRK_STOP: brk_r <= 1'b0;
          default: ;
        endcase
      end
    end
  end
  // ****************************************
  // Transmit queue and serialiser
  // ****************************************
  reg [7:0] txq [0:DEPTH-1];
  reg [QUEUE_AW-1:0] twp_r, trp_r;
  reg [QUEUE_AW:0] tcnt_r;
  reg [2:0] tst_r;
  reg [3:0] tdiv_r, tleft_r;
  reg [1:0] tstop_r;
  reg [7:0] tsh_r;
  reg txo_r, tpar_r;
  wire tq_push = reg_wr_stb & (reg_addr == `OFS_QUEUE) & tx_en_r & (tcnt_r != FULL_CNT);
  wire tx_tick = tx16 ? (rise[0] & (tdiv_r == `DIV_LAST)) : rise[0];
  wire tx_begin = tx_tick & (tcnt_r != 0) & ((tst_r == T_IDLE) |
                  ((tst_r == T_STOP) & (tstop_r == 2'h0)));
  wire tx_empty = (tst_r == T_IDLE) & (tcnt_r == 0);
  wire [7:0] tx_head = txq[trp_r] & (8'hFF >> (4'h8 - clen));
  wire [1:0] nstop = mr2_r[`MR2_TWO_STOP] ? 2'h2 : 2'h1;
  // Queue storage; the serialiser pops as it starts a character.
  always @(posedge clk_sys) begin
    if (clk_en & tq_push) txq[twp_r] <= reg_wr_data;
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      twp_r <= {QUEUE_AW{1'b0}};
      trp_r <= {QUEUE_AW{1'b0}};
      tcnt_r <= {(QUEUE_AW+1){1'b0}};
    end else if (clk_en) begin
      if (cmd_tx_rst) begin
        twp_r <= {QUEUE_AW{1'b0}};
        trp_r <= {QUEUE_AW{1'b0}};
        tcnt_r <= {(QUEUE_AW+1){1'b0}};
      end else begin
        if (tq_push) twp_r <= twp_r + 1'b1;
        if (tx_begin) trp_r <= trp_r + 1'b1;
        tcnt_r <= tcnt_r + {{QUEUE_AW{1'b0}}, tq_push} - {{QUEUE_AW{1'b0}}, tx_begin};
      end
    end
  end
  // Frame sequencer driven by the transmit bit clock.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tst_r <= T_IDLE;
      tdiv_r <= 4'h0;
      tleft_r <= 4'h0;
      tstop_r <= 2'h0;
      tsh_r <= 8'h00;
      tpar_r <= 1'b0;
      txo_r <= 1'b1;
    end else if (clk_en) begin
      if (cmd_tx_rst) begin
        tst_r <= T_IDLE;
        txo_r <= 1'b1;
      end else begin
        if (tq_push & tx_empty & tx16) tdiv_r <= `DIV_LAST;
        else if (rise[0]) tdiv_r <= tdiv_r + 4'h1;
        if (tx_begin) begin
          txo_r <= 1'b0;
          tsh_r <= tx_head;
          tleft_r <= clen;
          tpar_r <= (pmode == `PM_WITH) ? (^tx_head ^ mr1_r[`MR1_PTYPE])
                                        : mr1_r[`MR1_PTYPE];
          tst_r <= T_DATA;
        end else if (tx_tick) begin
          case (tst_r)
            T_DATA: begin
              if (tleft_r != 4'h0) begin
                txo_r <= tsh_r[0];
                tsh_r <= {1'b0, tsh_r[7:1]};
                tleft_r <= tleft_r - 4'h1;
              end else if (pmode != `PM_NONE) begin
                txo_r <= tpar_r;
                tstop_r <= nstop;
                tst_r <= T_STOP;
              end else begin
                txo_r <= 1'b1;
                tstop_r <= nstop - 2'h1;
                tst_r <= T_STOP;
              end
            end
            T_STOP: begin
              txo_r <= 1'b1;
              if (tstop_r != 2'h0) tstop_r <= tstop_r - 2'h1;
              else tst_r <= T_IDLE;
            end
            default: txo_r <= 1'b1;
          endcase
        end
      end
    end
  end
  // ****************************************
  // Receive deframer
  // ****************************************
  reg [2:0] rst_st_r;
  reg [3:0] rdiv_r, ridx_r;
  reg [7:0] rdat_r;
  reg rpar_r, rfall_r, ovr_r, hold_v_r;
  reg [10:0] ent_r, hold_r;
  reg [1:0] brk_hi_r;
  reg brk_chg_r, wdog_r;
  reg [QUEUE_AW:0] rcnt_r;
  wire rq_full = (rcnt_r == FULL_CNT);
  wire has_par = (pmode != `PM_NONE);
  wire [3:0] nframe = clen + {3'h0, has_par};
  wire samp = rx16 ? (rise[1] & (rdiv_r == `DIV_MID)) : rise[1];
  wire ld_ev = rx16 ? (rise[1] & (rdiv_r == `DIV_LAST)) : (rise[1] & rfall_r);
  wire rx_on = rx_en_r | wakeup;
  wire start_ok = ((rst_st_r == R_VALID) & samp & ~rxd) |
                  ((rst_st_r == R_HUNT) & ~rx16 & rx_on & rise[1] & ~rxd);
  wire keep = ~(wakeup & ~rx_en_r & ~ent_r[8]);
  wire rq_load = (rst_st_r == R_LOADW) & ld_ev & keep & ~rq_full;
  wire rq_drain = hold_v_r & ~rq_full & ~((rst_st_r == R_LOADW) & ld_ev);
  wire rq_push = rq_load | rq_drain;
  wire rq_pop = reg_rd_stb & (reg_addr == `OFS_QUEUE) & (rcnt_r != 0);
  wire last_bit = (ridx_r == nframe);
  wire rpe = (pmode == `PM_WITH) ? (^rdat_r ^ rpar_r ^ mr1_r[`MR1_PTYPE]) :
             (pmode == `PM_FORCE) ? (rpar_r ^ mr1_r[`MR1_PTYPE]) :
             (pmode == `PM_WAKEUP) ? rpar_r : 1'b0;
  wire all_low = (rdat_r == 8'h00) & ~(has_par & rpar_r) & ~rxd;
  // Hunt, validate, shift, load and break tracking.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_st_r <= R_HUNT;
      rdiv_r <= 4'h0;
      ridx_r <= 4'h0;
      rdat_r <= 8'h00;
      rpar_r <= 1'b0;
      rfall_r <= 1'b0;
      ent_r <= 11'h000;
      brk_hi_r <= 2'h0;
    end else if (clk_en) begin
      if (cmd_rx_rst) begin
        rst_st_r <= R_HUNT;
      end else begin
        if (rst_st_r == R_HUNT & rx16 & rx_on & fall[2]) rdiv_r <= 4'h0;
        else if (rise[1]) rdiv_r <= rdiv_r + 4'h1;
        if (start_ok) begin
          rst_st_r <= R_BITS;
          ridx_r <= 4'h0;
          rdat_r <= 8'h00;
        end else begin
          case (rst_st_r)
            R_HUNT: if (rx16 & rx_on & fall[2]) rst_st_r <= R_VALID;
            R_VALID: if (samp) rst_st_r <= R_HUNT;
            R_BITS: if (samp) begin
              ridx_r <= ridx_r + 4'h1;
              if (ridx_r < clen) rdat_r[ridx_r[2:0]] <= rxd;
              else if (!last_bit) rpar_r <= rxd;
              else begin
                ent_r <= {all_low, ~rxd, rpe & ~all_low, all_low ? 8'h00 : rdat_r};
                rfall_r <= 1'b0;
                rst_st_r <= R_LOADW;
              end
            end
            R_LOADW: begin
              if (fall[1]) rfall_r <= 1'b1;
              if (ld_ev) begin
                if (ent_r[10]) rst_st_r <= R_BRK;
                else if (rx16 & ent_r[9] & (ent_r[7:0] != 8'h00) & ~rxd) begin
                  rst_st_r <= R_VALID;
                  rdiv_r <= 4'h0;
                end else rst_st_r <= R_HUNT;
              end
              brk_hi_r <= 2'h0;
            end
            R_BRK: begin
              brk_hi_r <= rxd ? brk_hi_r + 2'h1 : 2'h0;
              if (rxd & (brk_hi_r + 2'h1 == `BRK_END_EDGES)) rst_st_r <= R_HUNT;
            end
            default: rst_st_r <= R_HUNT;
          endcase
        end
      end
    end
  end
  // ****************************************
  // Receive queue, hold register and status
  // ****************************************
  reg [10:0] rxq [0:DEPTH-1];
  reg [QUEUE_AW-1:0] rwp_r, rrp_r;
  reg [2:0] acc_r;
  reg [6:0] wd_r;
  wire [10:0] rq_in = rq_load ? ent_r : hold_r;
  wire [2:0] head_st = (rcnt_r != 0) ? rxq[rrp_r][10:8] : 3'h0;
  wire [2:0] err_st = mr1_r[`MR1_ERR_BLOCK] ? acc_r : head_st;
  wire brk_end = (rst_st_r == R_BRK) & rxd & (brk_hi_r + 2'h1 == `BRK_END_EDGES);
  wire brk_start = (rst_st_r == R_LOADW) & ld_ev & ent_r[10];
  wire rx_1x = rx16 ? (rise[1] & (rdiv_r == `DIV_LAST)) : rise[1];
  wire wd_hit = rx_1x & (wd_r == `WDOG_BIT_TIMES - 7'h1);
  wire isr_wr = cmd_wr & ((cmd == `CMD_BRK_CLR) | (cmd == `CMD_WDOG_CLR));
  wire [7:0] stat = {err_st, ovr_r, tx_empty, tcnt_r != FULL_CNT, rq_full, rcnt_r != 0};
  // Free transmit slots; an empty queue reports 7, otherwise the low three bits are reported.
  wire [QUEUE_AW:0] tfree = FULL_CNT - tcnt_r;
  // Character and its three status bits enter the queue together.
  always @(posedge clk_sys) begin
    if (clk_en & rq_push & ~cmd_rx_rst) rxq[rwp_r] <= rq_in;
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rwp_r <= {QUEUE_AW{1'b0}};
      rrp_r <= {QUEUE_AW{1'b0}};
      rcnt_r <= {(QUEUE_AW+1){1'b0}};
      hold_r <= 11'h000;
      hold_v_r <= 1'b0;
      ovr_r <= 1'b0;
      acc_r <= 3'h0;
      wd_r <= 7'h00;
      brk_chg_r <= 1'b0;
      wdog_r <= 1'b0;
    end else if (clk_en) begin
      if (cmd_rx_rst) begin
        rwp_r <= {QUEUE_AW{1'b0}};
        rrp_r <= {QUEUE_AW{1'b0}};
        rcnt_r <= {(QUEUE_AW+1){1'b0}};
        hold_v_r <= 1'b0;
      end else begin
        if (rq_push) rwp_r <= rwp_r + 1'b1;
        if (rq_pop) rrp_r <= rrp_r + 1'b1;
        rcnt_r <= rcnt_r + {{QUEUE_AW{1'b0}}, rq_push} - {{QUEUE_AW{1'b0}}, rq_pop};
        // A full queue parks the character; a new start bit discards it.
        if ((rst_st_r == R_LOADW) & ld_ev & keep & rq_full) begin
          hold_r <= ent_r;
          hold_v_r <= 1'b1;
        end else if (rq_drain | start_ok) hold_v_r <= 1'b0;
      end
      // Overrun and block status: a new event wins over the reset command.
      ovr_r <= (start_ok & hold_v_r & ~cmd_rx_rst) | (ovr_r & ~cmd_err_rst);
      acc_r <= head_st | (cmd_err_rst ? 3'h0 : acc_r);
      // Watchdog restarts on any receive queue push or pop and stops once expired.
      if (rq_push | rq_pop) wd_r <= 7'h00;
      else if (rx_1x & (wd_r != `WDOG_BIT_TIMES)) wd_r <= wd_r + 7'h01;
      brk_chg_r <= brk_start | brk_end | (brk_chg_r & ~(isr_wr & (cmd == `CMD_BRK_CLR)));
      wdog_r <= (wd_hit & mr0_r[`MR0_WDOG_EN] & ~(rq_push | rq_pop)) |
                (wdog_r & ~(isr_wr & (cmd == `CMD_WDOG_CLR)));
    end
  end
  // ****************************************
  // Read port and outputs
  // ****************************************
  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
      tx_serial_out <= 1'b1;
      tx_free_level <= 3'h7;
      rx_fill_level <= 3'h0;
    end else if (clk_en) begin
      reg_rd_data <= 8'h00;
      if (reg_rd_stb) begin
        case (reg_addr)
          `OFS_MODE_ZERO: reg_rd_data <= mr0_r;
          `OFS_MODE_ONE: reg_rd_data <= mr1_r;
          `OFS_MODE_TWO: reg_rd_data <= mr2_r;
          `OFS_CLK_SEL: reg_rd_data <= csel_r;
          `OFS_CMD_STAT: reg_rd_data <= stat;
          `OFS_QUEUE: reg_rd_data <= (rcnt_r != 0) ? rxq[rrp_r][7:0] : 8'h00;
          `OFS_INT_STAT: reg_rd_data <= {4'h0, wdog_r, brk_chg_r, 2'h0};
          `OFS_LEVELS: reg_rd_data <= {1'b0, tx_free_level, 1'b0, rx_fill_level};
          default: reg_rd_data <= 8'h00;
        endcase
      end
      tx_serial_out <= brk_r ? 1'b0 : txo_r;
      tx_free_level <= (tcnt_r == 0) ? 3'h7 : tfree[2:0];
      rx_fill_level <= rq_full ? 3'h7 : rcnt_r[2:0];
    end
  end
endmodule

//--- sim/async_serial_channel_props.sv
// Port-level assertions for the serial channel, attached to its top module.
`include "async_serial_channel_regs.vh"
module async_serial_channel_props (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_wr_stb,
  input wire logic       reg_rd_stb,
  input wire logic [7:0] reg_rd_data,
  input wire logic       tx_bit_clock,
  input wire logic       rx_bit_clock,
  input wire logic       rx_serial_in,
  input wire logic       tx_serial_out,
  input wire logic [2:0] tx_free_level,
  input wire logic [2:0] rx_fill_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ****************
  // Command tracking
  // ****************
  logic       tx_on_r;
  logic [2:0] brk_age_r;
  wire        cmd_wr = reg_wr_stb && clk_en && reg_addr == `OFS_CMD_STAT;
  wire        tx_rst = cmd_wr && reg_wr_data[3:0] == `CMD_TX_RST;
  wire        rx_rst = cmd_wr && reg_wr_data[3:0] == `CMD_RX_RST;
  wire        q_ok   = reg_wr_stb && clk_en && reg_addr == `OFS_QUEUE && tx_on_r;
  wire        q_rd   = reg_rd_stb && clk_en && reg_addr == `OFS_QUEUE;
  // Follows the transmitter enable and ages a commanded break, which avoids
  // judging the line in the few cycles the command needs to reach the pin.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_on_r <= 1'b0;
      brk_age_r <= 3'h0;
    end else if (cmd_wr) begin
      if (reg_wr_data[3:0] == `CMD_TX_EN) tx_on_r <= 1'b1;
      if (reg_wr_data[3:0] == `CMD_TX_DIS || tx_rst) tx_on_r <= 1'b0;
      if (reg_wr_data[3:0] == `CMD_BRK_START) brk_age_r <= 3'h1;
      if (reg_wr_data[3:0] == `CMD_BRK_STOP || tx_rst) brk_age_r <= 3'h0;
    end else if (brk_age_r != 3'h0 && brk_age_r != 3'h7) begin
      brk_age_r <= brk_age_r + 3'h1;
    end
  end
  // ****************
  // Assertions
  // ****************
  rd_idle_zero_a:
  assert property ($past(clk_en) && !$past(reg_rd_stb) |-> reg_rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  fill_step_a:
  assert property (rx_fill_level > $past(rx_fill_level) |->
                   rx_fill_level == $past(rx_fill_level) + 3'h1)
    else $error("receive fill rose by more than one");
  fill_drop_a:
  assert property (rx_fill_level < $past(rx_fill_level) |-> $past(q_rd) ||
                   $past(q_rd, 2) || $past(q_rd, 3) || $past(rx_rst) || $past(rx_rst, 2))
    else $error("receive fill fell without a queue read");
  free_step_a:
  assert property (tx_free_level < $past(tx_free_level) |->
                   tx_free_level == $past(tx_free_level) - 3'h1)
    else $error("transmit free count fell by more than one");
  free_drop_a:
  assert property (tx_free_level < $past(tx_free_level) |->
                   $past(q_ok) || $past(q_ok, 2) || $past(q_ok, 3))
    else $error("transmit queue took a write while disabled");
  brk_low_a:
  assert property (brk_age_r >= 3'h4 |-> !tx_serial_out)
    else $error("transmit line high during break");
  tx_rst_idle_a:
  assert property (tx_rst |-> ##[1:5] tx_serial_out && tx_free_level == 3'h7)
    else $error("transmitter reset left line low or queue occupied");
  rx_rst_clear_a:
  assert property (rx_rst |-> ##[1:5] rx_fill_level == 3'h0)
    else $error("receiver reset left characters queued");
endmodule
bind async_serial_channel async_serial_channel_props chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
  .reg_rd_data(reg_rd_data), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
  .rx_serial_in(rx_serial_in), .tx_serial_out(tx_serial_out),
  .tx_free_level(tx_free_level), .rx_fill_level(rx_fill_level));

//--- sim/serial_station.sv
// Remote serial station: sends frames on the receive line, captures transmitted frames.
module serial_station (
  input  wire logic        clk16,
  input  wire logic        tx_line,
  input  wire logic [3:0]  cap_bits,
  output logic             rx_line,
  output logic [11:0]      cap_word,
  output int               cap_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sends n bits LSB first, sixteen bit-clock ticks each, then marks the line.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (16) @(posedge clk16);
    end
    rx_line <= 1'b1;
  endtask
  // Samples each transmitted bit in mid-cell after a validated start bit.
  initial begin
    rx_line = 1'b1;
    cap_cnt = 0;
    cap_word = 12'h000;
    forever begin
      @(negedge tx_line);
      repeat (8) @(posedge clk16);
      if (!tx_line) begin
        for (int i = 0; i < cap_bits; i++) begin
          repeat (16) @(posedge clk16);
          cap_word[i] = tx_line;
        end
        cap_cnt++;
      end
    end
  end
endmodule

//--- sim/async_serial_channel_tb.sv
// Self-checking bench for the serial channel against a remote station model.
`include "async_serial_channel_regs.vh"
module async_serial_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_wr_stb = 1'b0;
  logic        reg_rd_stb = 1'b0;
  logic [7:0]  reg_rd_data, d;
  logic        bclk = 1'b0, bdiv = 1'b0, rxd, txd;
  logic [2:0]  tx_free_level, rx_fill_level;
  logic [3:0]  cap_bits = 4'h9;
  logic [11:0] cap_word;
  logic [7:0]  q[$];
  int          cap_cnt, n0, errors = 0, n_checks = 0, cycles = 0;
  // Clock, and a 16X bit clock at a quarter of its rate.
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    bdiv <= ~bdiv;
    if (bdiv) bclk <= ~bclk;
  end
  async_serial_channel dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_rd_data(reg_rd_data), .tx_bit_clock(bclk), .rx_bit_clock(bclk),
    .rx_serial_in(rxd), .tx_serial_out(txd), .tx_free_level(tx_free_level),
    .rx_fill_level(rx_fill_level));
  serial_station st (.clk16(bclk), .tx_line(txd), .cap_bits(cap_bits), .rx_line(rxd),
    .cap_word(cap_word), .cap_cnt(cap_cnt));
  // Ends the run with the counts and the verdict.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic check(input string nm, input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Register bus cycles: one-cycle strobes, read data in the following cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr_stb <= 1'b1;
    @(posedge clk_sys);
    reg_wr_stb <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(`OFS_CMD_STAT, {4'h0, c});
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge clk_sys);
    reg_rd_stb <= 1'b0;
    #1 d = reg_rd_data;
    check(nm, d, e);
  endtask
  // Expected line bits: start, data LSB first, optional parity slot, stop.
  function automatic logic [11:0] frame(input logic [7:0] v, input int len, input int par,
                                        input logic ad);
    frame = 12'hFFE;
    for (int i = 0; i < len; i++) frame[i + 1] = v[i];
    if (par != 0) frame[len + 1] = ad;
  endfunction
  task automatic tx_char(input logic [7:0] v, input int len, input int par, input logic ad);
    logic [11:0] m;
    n0 = cap_cnt;
    m = (12'h001 << (len + par + 1)) - 12'h001;
    cap_bits <= 4'(len + par + 1);
    wr(`OFS_QUEUE, v);
    for (int i = 0; i < 2000 && cap_cnt == n0; i++) idle(1);
    check("tx frame", cap_word & m, (frame(v, len, par, ad) >> 1) & m);
  endtask
  task automatic rx_char(input logic [7:0] v, input int len, input int par, input logic ad);
    st.send(frame(v, len, par, ad), len + par + 2);
    idle(20);
  endtask
  // ****************
  // Test sequence
  // ****************
  initial begin
    void'($urandom(32'h4F2D));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    idle(3);
    rdc("levels", `OFS_LEVELS, 8'h70);
    rdc("status", `OFS_CMD_STAT, 8'h0C);
    rdc("clock select", `OFS_CLK_SEL, `RST_CLK_SEL);
    rdc("unmapped", 4'hF, 8'h00);
    wr(`OFS_QUEUE, 8'h5A);
    idle(4);
    check("free refused", tx_free_level, 3'h7);
    rdc("refused status", `OFS_CMD_STAT, 8'h0C);
    clk_en <= 1'b0;
    wr(`OFS_MODE_TWO, 8'h01);
    clk_en <= 1'b1;
    rdc("frozen write", `OFS_MODE_TWO, 8'h00);
    $display("test reset done");
    cmd(`CMD_TX_EN);
    cmd(`CMD_RX_EN);
    for (int len = 5; len <= 8; len++) begin
      wr(`OFS_MODE_ONE, {3'h0, 2'h2, 1'b0, 2'(len - 5)});
      d = 8'($urandom);
      q.push_back(d);
      tx_char(d, len, 0, 1'b0);
      rx_char(d, len, 0, 1'b0);
      rdc("rx status", `OFS_CMD_STAT, 8'h0D);
      rdc("rx data", `OFS_QUEUE, q[len - 5] & (8'hFF >> (8 - len)));
    end
    $display("test lengths done");
    for (int ad = 0; ad < 2; ad++) begin
      wr(`OFS_MODE_ONE, {3'h0, 2'h3, 1'(ad), 2'h3});
      tx_char(8'($urandom), 8, 1, 1'(ad));
    end
    cmd(`CMD_RX_DIS);
    rx_char(8'hA5, 8, 1, 1'b0);
    rx_char(8'h3C, 8, 1, 1'b1);
    rdc("wake status", `OFS_CMD_STAT, 8'h2D);
    rdc("wake data", `OFS_QUEUE, 8'h3C);
    cmd(`CMD_RX_EN);
    wr(`OFS_MODE_ONE, 8'h13);
    $display("test wake-up done");
    n0 = cap_cnt;
    cap_bits <= 4'h9;
    for (int i = 0; i < 3; i++) wr(`OFS_QUEUE, 8'h30 + 8'(i));
    cmd(`CMD_TX_DIS);
    wr(`OFS_QUEUE, 8'hEE);
    idle(2600);
    check("drained count", 12'(cap_cnt - n0), 12'h003);
    check("last frame", cap_word & 12'h1FF, 12'h132);
    rdc("drained status", `OFS_CMD_STAT, 8'h0C);
    cmd(`CMD_TX_EN);
    cmd(`CMD_BRK_START);
    idle(100);
    check("break line", txd, 1'b0);
    cmd(`CMD_BRK_STOP);
    idle(8);
    check("break over", txd, 1'b1);
    cmd(`CMD_BRK_START);
    cmd(`CMD_TX_RST);
    idle(8);
    check("reset line", txd, 1'b1);
    check("reset free", tx_free_level, 3'h7);
    cmd(`CMD_TX_EN);
    idle(800);
    $display("test transmit done");
    q.delete();
    for (int i = 0; i < 10; i++) begin
      q.push_back(8'($urandom));
      rx_char(q[i], 8, 0, 1'b0);
    end
    check("fill full", rx_fill_level, 3'h7);
    rdc("overrun", `OFS_CMD_STAT, 8'h1F);
    check("fill kept", rx_fill_level, 3'h7);
    for (int i = 0; i < 8; i++) rdc("queue", `OFS_QUEUE, q[i]);
    idle(200);
    rdc("waiting char", `OFS_QUEUE, q[9]);
    cmd(`CMD_ERR_RST);
    rdc("errors reset", `OFS_CMD_STAT, 8'h0C);
    $display("test overrun done");
    st.send(12'h000, 12);
    idle(200);
    check("one break char", rx_fill_level, 3'h1);
    rdc("break status", `OFS_CMD_STAT, 8'hCD);
    check("break bit", d & 8'h81, 8'h81);
    rdc("break change", `OFS_INT_STAT, 8'h04);
    cmd(`CMD_BRK_CLR);
    rdc("change cleared", `OFS_INT_STAT, 8'h00);
    rdc("break data", `OFS_QUEUE, 8'h00);
    wr(`OFS_MODE_ONE, 8'h33);
    rdc("block status", `OFS_CMD_STAT, 8'hCC);
    cmd(`CMD_ERR_RST);
    rdc("block cleared", `OFS_CMD_STAT, 8'h0C);
    wr(`OFS_MODE_ONE, 8'h13);
    $display("test break done");
    wr(`OFS_MODE_ZERO, 8'h80);
    rx_char(8'h66, 8, 0, 1'b0);
    idle(3600);
    rdc("watchdog early", `OFS_INT_STAT, 8'h00);
    idle(700);
    rdc("watchdog fired", `OFS_INT_STAT, 8'h08);
    cmd(`CMD_WDOG_CLR);
    rdc("watchdog data", `OFS_QUEUE, 8'h66);
    cmd(`CMD_RX_RST);
    idle(8);
    check("rx reset fill", rx_fill_level, 3'h0);
    $display("test watchdog done");
    tally_and_finish;
  end
endmodule
